// ### core/codec_sap_host_pkg.sv
// Constants and register maps for the serial audio host
package codec_sap_host_pkg;

    // Avalon-MM slave geometry
    localparam int AV_ADDR_W = 8;
    localparam int AV_DATA_W = 32;

    // Own register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] TX_BASE    = 8'h20;
    localparam logic [7:0] RX0_BASE   = 8'h40;
    localparam logic [7:0] RX1_BASE   = 8'h60;

    // Control register field positions
    localparam int CTRL_EN_BIT       = 0;
    localparam int CTRL_MASTER_BIT   = 1;
    localparam int CTRL_POL_BIT      = 2;
    localparam int CTRL_TYPE_BIT     = 3;
    localparam int CTRL_EDGE_BIT     = 4;
    localparam int CTRL_MSB_LSB      = 5;
    localparam int CTRL_SLOTS_LSB    = 7;
    localparam int CTRL_SLOTBITS_LSB = 10;
    localparam int CTRL_DIV_LSB      = 16;

    // Status register field positions
    localparam int STAT_FRAMES_LSB = 0;
    localparam int STAT_SYNC_BIT   = 16;

    // Reset values of the control fields
    localparam logic [5:0] SLOTBITS_RST = 6'h20;
    localparam logic [7:0] DIV_RST      = 8'h03;

    // Words are held in the low 24 bits
    localparam logic [5:0] WORD_MAX  = 6'h18;
    localparam logic [5:0] WORD_16   = 6'h10;
    localparam logic [4:0] WORD_MSB  = 5'h17;

    // MSB position encodings
    typedef enum logic [1:0] {
        MSB_DELAY1  = 2'b00,
        MSB_ALIGNED = 2'b01,
        MSB_RJ24    = 2'b10,
        MSB_RJ16    = 2'b11
    } msb_pos_t;

    // Frame layouts
    typedef enum logic [1:0] {
        SLOTS_2 = 2'b00,
        SLOTS_4 = 2'b01,
        SLOTS_8 = 2'b10
    } slot_mode_t;

    // Device control-port map, for software's own port
    localparam logic [15:0] DEV_CLOCK_ENABLE_CTRL     = 16'h0000;
    localparam logic [15:0] DEV_PLAYBACK_ROUTE_SEL    = 16'h0011;
    localparam logic [15:0] DEV_SERIAL_OUT_SLOT_MAP_A = 16'h0013;
    localparam logic [15:0] DEV_SERIAL_OUT_SLOT_MAP_B = 16'h0014;
    localparam logic [15:0] DEV_SERIAL_OUT_SLOT_MAP_C = 16'h0015;
    localparam logic [15:0] DEV_SERIAL_OUT_SLOT_MAP_D = 16'h0016;
    localparam logic [15:0] DEV_OUT_RATE_CONV_SRC_A   = 16'h0018;
    localparam logic [15:0] DEV_OUT_RATE_CONV_SRC_B   = 16'h0019;
    localparam logic [15:0] DEV_RATE_CONV_ENABLE      = 16'h001A;
    localparam logic [15:0] DEV_CAPTURE_CTRL_A        = 16'h001B;
    localparam logic [15:0] DEV_CAPTURE_CTRL_B        = 16'h001C;
    localparam logic [15:0] DEV_CAPTURE_CTRL_C        = 16'h001D;
    localparam logic [15:0] DEV_CAPTURE_CTRL_D        = 16'h001E;
    localparam logic [15:0] DEV_PLAYBACK_CTRL         = 16'h002E;
    localparam logic [15:0] DEV_OUTPUT_STAGE_MUTES    = 16'h0031;
    localparam logic [15:0] DEV_SERIAL_FORMAT_CTRL_A  = 16'h0032;
    localparam logic [15:0] DEV_SERIAL_FORMAT_CTRL_B  = 16'h0033;
    localparam logic [15:0] DEV_SERIAL_OUT_CH_ACTIVE  = 16'h0034;
    localparam logic [15:0] DEV_PIN1_FUNCTION_MODE    = 16'h0039;
    localparam logic [15:0] DEV_PIN6_FUNCTION_MODE    = 16'h003E;
    localparam logic [15:0] DEV_OUTPUT_STAGE_POWER    = 16'h0043;
    localparam logic [15:0] DEV_DECIMATOR_POWER       = 16'h0044;
    localparam logic [15:0] DEV_INTERPOLATOR_POWER    = 16'h0045;
    localparam logic [15:0] DEV_PAD_DRIVE_CTRL        = 16'h004C;

    // Bring-up values: pins to serial out, all decimators on
    localparam logic [7:0] DEV_PIN_SERIAL_OUT = 8'h00;
    localparam logic [7:0] DEV_DECIM_ALL_ON   = 8'hFF;

endpackage : codec_sap_host_pkg

// ### core/codec_sap_host.sv
// Serial audio port host: clocks, playback and capture
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// What the device asks of this block and its software
// - Sample words are two's complement, sent and taken MSB first.
// - In 2-channel frames the left word precedes the right word.
// - Frame clock and bit clock stay synchronous to each other.
// - Use high pad drive at low supply with fast serial clocks.
// - 2-channel settings: type 0, edge 0, polarity/MSB per format.
// - TDM settings: polarity 1, edge 0, MSB 00, type either.
// - PCM settings: polarity 1; short sync 1/00, long sync 0/01.
// - Clocks initialised and gate set before serial port setup.
// - Capture bring-up: pins 0x00, decimators 0xFF, then enables, unmute.
// - Playback bring-up: power, converters, route, enable, unmute.
module codec_sap_host (
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    reset,
    // Avalon-MM slave
    input  wire logic [codec_sap_host_pkg::AV_ADDR_W-1:0] avsAddress,
    input  wire logic                                    avsRead,
    input  wire logic                                    avsWrite,
    input  wire logic [codec_sap_host_pkg::AV_DATA_W-1:0] avsWriteData,
    output logic      [codec_sap_host_pkg::AV_DATA_W-1:0] avsReadData,
    output logic                                         avsWaitRequest,
    // Bit clock pin, two-way
    input  wire logic                                    bitClockIn,
    output logic                                         bitClockOut,
    output logic                                         bitClockOeN,
    // Frame clock pin, two-way
    input  wire logic                                    frameClockIn,
    output logic                                         frameClockOut,
    output logic                                         frameClockOeN,
    // Serial data lines
    output logic                                         playbackInLine,
    input  wire logic                                    captureOutLine0,
    input  wire logic                                    captureOutLine1
);
    import codec_sap_host_pkg::*;

    // All state of the host
    typedef struct packed {
        logic              waitReq;
        logic [31:0]       readData;
        logic              enable;
        logic              master;
        logic              fsPol;
        logic              fsType;
        logic              edgeSel;
        msb_pos_t          msbSel;
        slot_mode_t        slotMode;
        logic [5:0]        slotBits;
        logic [7:0]        div;
        logic [7:0]        divCnt;
        logic              bclkOut;
        logic              lrOut;
        logic              clkOeN;
        logic              playOut;
        logic [1:0]        bclkSync;
        logic [1:0]        lrSync;
        logic [1:0]        cap0Sync;
        logic [1:0]        cap1Sync;
        logic              bclkPrev;
        logic              lrPrev;
        logic [2:0]        slot;
        logic [5:0]        bitIdx;
        logic [8:0]        posCnt;
        logic [15:0]       frames;
        logic              inSync;
        logic [7:0][23:0]  tx;
        logic [7:0][23:0]  rx0;
        logic [7:0][23:0]  rx1;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // Next slot and bit position within the frame
    function automatic logic [8:0] advance(input logic [2:0] sl,
                                           input logic [5:0] b,
                                           input logic [2:0] last,
                                           input logic [5:0] sb);
        logic [8:0] r;
        if (b == sb - 6'd1) begin
            r = (sl == last) ? 9'h000 : {sl + 3'd1, 6'd0};
        end else begin
            r = {sl, b + 6'd1};
        end
        return r;
    endfunction : advance

    // Valid flag and MSB-first index of a bit
    function automatic logic [6:0] word_bit(input logic [5:0] b,
                                            input logic [5:0] start,
                                            input logic [5:0] len);
        logic [5:0] k;
        k = b - start;
        return {(b >= start) && (k < len), k};
    endfunction : word_bit

    // Decode and engine temporaries
    logic       mRise;
    logic       mFall;
    logic       sRise;
    logic       sFall;
    logic       sampleEv;
    logic       launchEv;
    logic       lrNow;
    logic       frameStart;
    logic [2:0] lastSlot;
    logic [8:0] frameLen;
    logic [8:0] nextPos;
    logic [5:0] wordLen;
    logic [5:0] wordStart;
    logic [8:0] pPos;
    logic [8:0] qPos;
    logic [6:0] pWord;
    logic [6:0] qWord;
    logic [2:0] region;
    logic [2:0] sel;
    logic [31:0] rdData;

    // Whole next-state computation
    always_comb begin
        s_next     = s_reg;
        mRise      = 1'b0;
        mFall      = 1'b0;
        pPos       = 9'h000;
        pWord      = 7'h00;
        qWord      = 7'h00;
        nextPos    = 9'h000;
        frameStart = 1'b0;
        region     = avsAddress[7:5];
        sel        = avsAddress[4:2];

        // Pins pass two flops before any logic
        s_next.bclkSync = {s_reg.bclkSync[0], bitClockIn};
        s_next.lrSync   = {s_reg.lrSync[0], frameClockIn};
        s_next.cap0Sync = {s_reg.cap0Sync[0], captureOutLine0};
        s_next.cap1Sync = {s_reg.cap1Sync[0], captureOutLine1};
        s_next.bclkPrev = s_reg.bclkSync[1];

        // Frame geometry from the slot layout
        case (s_reg.slotMode)
            SLOTS_4: begin
                lastSlot = 3'd3;
                frameLen = {1'b0, s_reg.slotBits, 2'b00};
            end
            SLOTS_8: begin
                lastSlot = 3'd7;
                frameLen = {s_reg.slotBits, 3'b000};
            end
            default: begin
                lastSlot = 3'd1;
                frameLen = {2'b00, s_reg.slotBits, 1'b0};
            end
        endcase

        // Right justified words end at slot end; others take up to 24 bits
        case (s_reg.msbSel)
            MSB_RJ24: begin
                wordLen   = WORD_MAX;
                wordStart = s_reg.slotBits - WORD_MAX;
            end
            MSB_RJ16: begin
                wordLen   = WORD_16;
                wordStart = s_reg.slotBits - WORD_16;
            end
            default: begin
                wordLen   = (s_reg.slotBits < WORD_MAX) ? s_reg.slotBits
                                                        : WORD_MAX;
                wordStart = 6'd0;
            end
        endcase

        // Master divider makes the bit clock
        if (s_reg.enable && s_reg.master) begin
            if (s_reg.divCnt == s_reg.div) begin
                s_next.divCnt  = 8'h00;
                s_next.bclkOut = ~s_reg.bclkOut;
                mRise          = ~s_reg.bclkOut;
                mFall          = s_reg.bclkOut;
            end else begin
                s_next.divCnt = s_reg.divCnt + 8'd1;
            end
        end else begin
            s_next.divCnt = 8'h00;
        end

        // Both directions follow the one clock pair
        sRise    = s_reg.bclkSync[1] & ~s_reg.bclkPrev;
        sFall    = ~s_reg.bclkSync[1] & s_reg.bclkPrev;
        s_next.clkOeN = ~s_reg.master;
        if (!s_reg.enable) begin
            sampleEv = 1'b0;
            launchEv = 1'b0;
        end else if (s_reg.master) begin
            sampleEv = s_reg.edgeSel ? mFall : mRise;
            launchEv = s_reg.edgeSel ? mRise : mFall;
        end else begin
            sampleEv = s_reg.edgeSel ? sFall : sRise;
            launchEv = s_reg.edgeSel ? sRise : sFall;
        end
        lrNow = s_reg.master ? s_reg.lrOut : s_reg.lrSync[1];

        // Sample edge: find frame start, take capture bits
        qPos = advance(s_reg.slot, s_reg.bitIdx, lastSlot, s_reg.slotBits);
        if (sampleEv) begin
            s_next.lrPrev = lrNow;
            frameStart    = (lrNow == s_reg.fsPol) &&
                            (s_reg.lrPrev != s_reg.fsPol);
            if (frameStart) begin
                // Delayed MSB: the sync bit is the previous frame's tail
                pPos = (s_reg.msbSel == MSB_DELAY1)
                     ? {lastSlot, s_reg.slotBits - 6'd1} : 9'h000;
                s_next.frames = s_reg.frames + 16'd1;
                s_next.inSync = 1'b1;
            end else begin
                pPos = qPos;
            end
            s_next.slot   = pPos[8:6];
            s_next.bitIdx = pPos[5:0];
            pWord = word_bit(pPos[5:0], wordStart, wordLen);
            // Bits past the word length are dropped
            if (pWord[6] && (s_reg.inSync || frameStart)) begin
                s_next.rx0[pPos[8:6]][WORD_MSB - pWord[4:0]] =
                    s_reg.cap0Sync[1];
                s_next.rx1[pPos[8:6]][WORD_MSB - pWord[4:0]] =
                    s_reg.cap1Sync[1];
            end
        end

        // Launch edge: playback bit and master frame clock
        if (launchEv) begin
            qWord = word_bit(qPos[5:0], wordStart, wordLen);
            // Slot 0 is left, so left always goes first
            s_next.playOut = qWord[6] ?
                s_reg.tx[qPos[8:6]][WORD_MSB - qWord[4:0]] : 1'b0;
            nextPos = (s_reg.posCnt == frameLen - 9'd1) ? 9'h000
                                                        : s_reg.posCnt + 9'd1;
            s_next.posCnt = nextPos;
            if (s_reg.master) begin
                // Square or one-bit pulse from one counter
                if (s_reg.fsType) begin
                    s_next.lrOut = (nextPos == 9'h000) ? s_reg.fsPol
                                                       : ~s_reg.fsPol;
                end else begin
                    s_next.lrOut = (nextPos < (frameLen >> 1)) ? s_reg.fsPol
                                                               : ~s_reg.fsPol;
                end
            end
        end

        // Register read mux; unmapped words read as zero
        case (region)
            3'd0: begin
                if (sel == CTRL_OFS[4:2]) begin
                    rdData = 32'h0000_0000;
                    rdData[CTRL_EN_BIT]     = s_reg.enable;
                    rdData[CTRL_MASTER_BIT] = s_reg.master;
                    rdData[CTRL_POL_BIT]    = s_reg.fsPol;
                    rdData[CTRL_TYPE_BIT]   = s_reg.fsType;
                    rdData[CTRL_EDGE_BIT]   = s_reg.edgeSel;
                    rdData[CTRL_MSB_LSB +: 2]      = s_reg.msbSel;
                    rdData[CTRL_SLOTS_LSB +: 2]    = s_reg.slotMode;
                    rdData[CTRL_SLOTBITS_LSB +: 6] = s_reg.slotBits;
                    rdData[CTRL_DIV_LSB +: 8]      = s_reg.div;
                end else if (sel == STATUS_OFS[4:2]) begin
                    rdData = 32'h0000_0000;
                    rdData[STAT_FRAMES_LSB +: 16] = s_reg.frames;
                    rdData[STAT_SYNC_BIT]         = s_reg.inSync;
                end else begin
                    rdData = 32'h0000_0000;
                end
            end
            3'd1:    rdData = {8'h00, s_reg.tx[sel]};
            3'd2:    rdData = {8'h00, s_reg.rx0[sel]};
            3'd3:    rdData = {8'h00, s_reg.rx1[sel]};
            default: rdData = 32'h0000_0000;
        endcase

        // Slave handshake: one wait cycle, then one answer cycle
        s_next.waitReq = 1'b1;
        if ((avsRead || avsWrite) && s_reg.waitReq) begin
            s_next.waitReq  = 1'b0;
            s_next.readData = avsRead ? rdData : 32'h0000_0000;
        end

        // Writes land on the edge that sees waitrequest low
        if (avsWrite && !s_reg.waitReq) begin
            if (region == 3'd0 && sel == CTRL_OFS[4:2]) begin
                s_next.enable   = avsWriteData[CTRL_EN_BIT];
                s_next.master   = avsWriteData[CTRL_MASTER_BIT];
                s_next.fsPol    = avsWriteData[CTRL_POL_BIT];
                s_next.fsType   = avsWriteData[CTRL_TYPE_BIT];
                s_next.edgeSel  = avsWriteData[CTRL_EDGE_BIT];
                s_next.msbSel   =
                    msb_pos_t'(avsWriteData[CTRL_MSB_LSB +: 2]);
                s_next.slotMode =
                    slot_mode_t'(avsWriteData[CTRL_SLOTS_LSB +: 2]);
                s_next.slotBits = avsWriteData[CTRL_SLOTBITS_LSB +: 6];
                s_next.div      = avsWriteData[CTRL_DIV_LSB +: 8];
                // Turning off drops frame lock so a restart resyncs
                if (!avsWriteData[CTRL_EN_BIT]) begin
                    s_next.inSync = 1'b0;
                end
            end else if (region == 3'd1) begin
                s_next.tx[sel] = avsWriteData[23:0];
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg          <= '0;
            s_reg.waitReq  <= 1'b1;
            s_reg.clkOeN   <= 1'b1;
            s_reg.slotBits <= SLOTBITS_RST;
            s_reg.div      <= DIV_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign avsReadData    = s_reg.readData;
    assign avsWaitRequest = s_reg.waitReq;
    assign bitClockOut    = s_reg.bclkOut;
    assign bitClockOeN    = s_reg.clkOeN;
    assign frameClockOut  = s_reg.lrOut;
    assign frameClockOeN  = s_reg.clkOeN;
    assign playbackInLine = s_reg.playOut;

endmodule : codec_sap_host

// ### dv/codec_sap_host_checker.sv
// Assertions on the host's pins and bus
`timescale 1ns/1ps
module codec_sap_host_checker
    import codec_sap_host_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // Avalon-MM slave
    input wire logic [AV_ADDR_W-1:0] avsAddress,
    input wire logic                 avsRead,
    input wire logic                 avsWrite,
    input wire logic [AV_DATA_W-1:0] avsWriteData,
    input wire logic [AV_DATA_W-1:0] avsReadData,
    input wire logic                 avsWaitRequest,
    // Serial pins
    input wire logic                 bitClockIn,
    input wire logic                 bitClockOut,
    input wire logic                 bitClockOeN,
    input wire logic                 frameClockIn,
    input wire logic                 frameClockOut,
    input wire logic                 frameClockOeN,
    input wire logic                 playbackInLine,
    input wire logic                 captureOutLine0,
    input wire logic                 captureOutLine1
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Bit clock edge now or a clock ago: launch changes on the same clock as the edge
    logic bclkPrev;
    logic bclkEdgeD;
    always_ff @(posedge clk) begin
        bclkPrev  <= bitClockOut;
        bclkEdgeD <= bitClockOut != bclkPrev;
    end
    wire bclkNear = (bitClockOut != bclkPrev) || bclkEdgeD;

    AST_WAIT_ONE: assert property (
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("answer late");
    AST_WAIT_PULSE: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("answer too long");
    AST_RESET_STATE: assert property ($fell(reset) |-> avsWaitRequest &&
        bitClockOeN && !bitClockOut && !frameClockOut && !playbackInLine)
        else $error("pins not at rest");
    AST_WRITE_ZERO: assert property (
        avsWrite && !avsWaitRequest |-> avsReadData == '0)
        else $error("read data on write");
    AST_UNMAPPED: assert property (
        avsRead && !avsWaitRequest && avsAddress[7] |-> avsReadData == '0)
        else $error("unmapped read data");
    AST_OE_PAIR: assert property (bitClockOeN == frameClockOeN)
        else $error("clock OE differ");
    AST_FRAME_ON_BCLK: assert property (!frameClockOeN &&
        !$past(frameClockOeN) && $changed(frameClockOut) |-> bclkNear)
        else $error("frame clock off edge");
    AST_PLAY_ON_BCLK: assert property (!bitClockOeN &&
        !$past(bitClockOeN) && $changed(playbackInLine) |-> bclkNear)
        else $error("playback off edge");
    AST_BCLK_HOLD: assert property (
        !bitClockOeN && $changed(bitClockOut)
        |=> ($stable(bitClockOut) || bitClockOeN) [*2])
        else $error("bit clock too fast");

    CVR_MASTER_FRAME: cover property (!frameClockOeN && $rose(frameClockOut));
    CVR_SLAVE_RUN: cover property (bitClockOeN && $rose(bitClockIn));
    CVR_UNMAPPED: cover property (avsRead && !avsWaitRequest && avsAddress[7]);
endmodule : codec_sap_host_checker

bind codec_sap_host codec_sap_host_checker i_codec_sap_host_checker (
    .clk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsReadData, .avsWaitRequest, .bitClockIn, .bitClockOut, .bitClockOeN,
    .frameClockIn, .frameClockOut, .frameClockOeN, .playbackInLine,
    .captureOutLine0, .captureOutLine1);

// ### dv/codec_device_model.sv
// Model of the codec's serial audio port
`timescale 1ns/1ps
module codec_device_model #(
    parameter int SLOT_BITS = 32
) (
    // Pins as seen at the device
    input  wire logic       bitClk,
    input  wire logic       frameClk,
    input  wire logic       playbackInLine,
    output logic            captureOutLine0,
    output logic            captureOutLine1,
    // Clock making and frame layout
    input  wire logic       makeClocks,
    output logic            genBitClk,
    output logic            genFrameClk,
    input  wire logic       polarity,
    input  wire logic [1:0] bitDelay,
    input  wire logic [3:0] slotCount
);
    logic [23:0] playWord [8];
    logic [23:0] w0;
    logic [23:0] w1;
    logic        lastFrame = 1'b0;
    int          bitIdx = 0;
    int          genCnt = 0;
    int          pos;
    int          len;

    assign len = int'(slotCount) * SLOT_BITS;

    // Frame starts when the frame clock turns to polarity
    always @(posedge bitClk) begin
        bitIdx    = (frameClk == polarity && lastFrame != polarity) ? 0
                    : bitIdx + 1;
        lastFrame = frameClk;
        pos       = bitIdx - int'(bitDelay);
        if (pos >= 0 && pos % SLOT_BITS < 24 && pos < len) begin
            playWord[pos / SLOT_BITS][23 - pos % SLOT_BITS] = playbackInLine;
        end
    end

    // Launch after the fall, frame clock settled
    always @(negedge bitClk) begin
        #25;
        pos = ((frameClk == polarity && lastFrame != polarity) ? 0
              : bitIdx + 1) - int'(bitDelay);
        w0  = 24'hC0_0A50 ^ 24'(pos / SLOT_BITS << 16);
        w1  = w0 ^ 24'h00_0010;
        if (pos >= 0 && pos % SLOT_BITS < 24 && pos < len) begin
            captureOutLine0 = w0[23 - pos % SLOT_BITS];
            captureOutLine1 = w1[23 - pos % SLOT_BITS];
        end else begin
            captureOutLine0 = !captureOutLine0;
            captureOutLine1 = !captureOutLine1;
        end
    end

    // Clocks stand still unless asked to run; the pair moves together
    initial begin
        genBitClk       = 1'b0;
        genFrameClk     = 1'b0;
        captureOutLine0 = 1'b0;
        captureOutLine1 = 1'b0;
        #3;
        forever begin
            #80;
            if (makeClocks) begin
                genBitClk = !genBitClk;
                if (!genBitClk) begin
                    genCnt      = (genCnt + 1) % len;
                    genFrameClk = (genCnt < len / 2) ? polarity : !polarity;
                end
            end
        end
    end
endmodule : codec_device_model

// ### dv/codec_sap_host_tb.sv
// Bench for the serial audio port host
`timescale 1ns/1ps
module codec_sap_host_tb;
    import codec_sap_host_pkg::*;
    // Clock, reset and Avalon master side
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  avsAddress = 8'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [31:0] avsReadData;
    logic [31:0] q;
    logic        avsWaitRequest;
    // Serial pins and model layout
    logic        bitClockOut, bitClockOeN, frameClockOut, frameClockOeN;
    logic        bitClk, frameClk, genBitClk, genFrameClk, playbackInLine;
    logic        captureOutLine0, captureOutLine1;
    logic        makeClocks = 1'b0;
    logic        pol = 1'b0;
    logic [1:0]  bitDelay = 2'b01;
    logic [3:0]  slotCount = 4'h2;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    // Clock and run-length ceiling
    always #10 clk = !clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            results();
        end
    end

    // Each clock pin carries the enabled driver
    assign bitClk   = bitClockOeN ? genBitClk : bitClockOut;
    assign frameClk = frameClockOeN ? genFrameClk : frameClockOut;

    codec_sap_host i_codec_sap_host (
        .clk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
        .avsReadData, .avsWaitRequest, .bitClockIn(bitClk), .bitClockOut,
        .bitClockOeN, .frameClockIn(frameClk), .frameClockOut,
        .frameClockOeN, .playbackInLine, .captureOutLine0,
        .captureOutLine1);
    codec_device_model i_codec_device_model (
        .bitClk, .frameClk, .makeClocks, .genBitClk, .genFrameClk,
        .playbackInLine, .captureOutLine0, .captureOutLine1,
        .polarity(pol), .bitDelay, .slotCount);

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One bus access, held until waitrequest low
    task automatic avs(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        avsAddress   <= a;
        avsWrite     <= wr;
        avsRead      <= !wr;
        avsWriteData <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 100);
        q = avsReadData;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask : avs

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        avs(1'b0, a, 32'h0000_0000);
        check(what, exp, q);
    endtask : rd

    // Waits for n frame starts, bounded
    task automatic frames(input int n);
        logic [15:0] start;
        int          k;
        avs(1'b0, STATUS_OFS, 32'h0000_0000);
        start = q[15:0];
        k     = 0;
        do begin
            avs(1'b0, STATUS_OFS, 32'h0000_0000);
            k++;
        end while (int'(q[15:0] - start) < n && k < 5000);
    endtask : frames

    function automatic logic [31:0] tx(input int i);
        return 32'h0080_5A00 ^ (32'(i) << 20);
    endfunction : tx

    // Loads slots, runs frames, checks both ways
    task automatic run(input logic m, p, t, input logic [1:0] f, s,
                       input int n);
        pol       <= p;
        bitDelay  <= (f == MSB_DELAY1) ? 2'b01 : 2'b00;
        slotCount <= 4'(n);
        for (int i = 0; i < n; i++) avs(1'b1, TX_BASE + 8'(4 * i), tx(i));
        avs(1'b1, CTRL_OFS,
            {8'h00, DIV_RST, SLOTBITS_RST, 1'b0, s, f, 1'b0, t, p, m, 1'b1});
        makeClocks <= !m;
        frames(4);
        makeClocks <= 1'b0;
        avs(1'b1, CTRL_OFS, 32'h0000_0000);
        for (int i = 0; i < n; i++) begin
            check("playback", tx(i), {8'h00,
                  i_codec_device_model.playWord[i]});
            rd(RX0_BASE + 8'(4 * i), 32'h00C0_0A50 ^ (32'(i) << 16),
               "line0");
            rd(RX1_BASE + 8'(4 * i), 32'h00C0_0A40 ^ (32'(i) << 16),
               "line1");
        end
    endtask : run

    task automatic regs_test();
        rd(CTRL_OFS, {8'h00, DIV_RST, SLOTBITS_RST, 10'h000}, "ctrl");
        avs(1'b1, TX_BASE + 8'h1C, 32'h0012_3456);
        rd(TX_BASE + 8'h1C, 32'h0012_3456, "tx slot");
        avs(1'b1, RX0_BASE, 32'h00FF_FFFF);
        rd(RX0_BASE, 32'h0000_0000, "rx read-only");
        avs(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
        rd(STATUS_OFS, 32'h0000_0000, "status read-only");
        rd(8'h80, 32'h0000_0000, "unmapped");
    endtask : regs_test

    // Reset, then registers, master formats and a slave run
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        regs_test();
        run(1'b1, 1'b0, 1'b0, MSB_DELAY1, SLOTS_2, 2);
        run(1'b1, 1'b1, 1'b0, MSB_DELAY1, SLOTS_4, 4);
        run(1'b1, 1'b1, 1'b1, MSB_DELAY1, SLOTS_8, 8);
        run(1'b0, 1'b1, 1'b0, MSB_ALIGNED, SLOTS_2, 2);
        results();
    end
endmodule : codec_sap_host_tb
